/* design/cmc_core.sv */
/*
  Codec channel mute, phase, zero flag, de-emphasis and power control.
  Registers are written over the 3-wire serial control pins; the DAC and
  ADC sample streams arrive on sys_clk with one-cycle sample strobes.
*/
// Contract
// R1: Phase bit n inverts both outputs of DAC channel n; field resets zero.
// R2: With zero cross enabled, new volume waits for a zero crossing.
// R3: Zero flag pin rises after 1024 consecutive zero samples on chosen channels.
// R4: Flag select 00 all channels, 01 channel 1, 10 channel 2, 11 channel 3.
// R5: Per-channel soft mute bit n soft-mutes DAC channel n; any combination.
// R6: Global soft mute bit soft-mutes all DAC channels; clearing restores.
// R7: Routing zero, power-down or zero attenuation mute abruptly, no ramp. Zero attenuation is not decoded here; it only passes on dac_volume_applied.
// R8: ADC mute register bits mute right, left, and both ADC inputs.
// R9: De-emphasis bit n enables de-emphasis on DAC channel n.
// R10: Global de-emphasis bit applies de-emphasis to all DAC channels.
// R11: Global power-down stops all DACs, clears history, keeps registers.
// R12: Clearing global power-down reinitialises the DAC filters.
// R13: ADC disable enters low power, resets filters; clearing reinitialises them.
// R14: DAC disable bit n puts DAC channel n in low power.
// R15: With mute pin decode disabled, a high mute pin soft-mutes all DACs.
// R16: Soft mute ramps gain down per sample and ramps back up on release.
`timescale 1ns/1ps
module cmc_core
  import cmc_pkg::*;
(
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // Serial control pins
  input  wire logic                    ser_clk,
  input  wire logic                    ser_data,
  input  wire logic                    ser_latch,
  // Mute pin, two-way
  input  wire logic                    mute_pin_in,
  output logic                         zero_flag_pin,
  output logic                         zero_flag_pin_oe_n,
  // DAC sample input
  input  wire logic                    dac_sample_stb,
  input  wire logic [2:0][23:0]        dac_in_l,
  input  wire logic [2:0][23:0]        dac_in_r,
  input  wire logic [2:0][7:0]         dac_volume_target,
  // DAC sample output and control
  output logic                         dac_out_stb,
  output logic [2:0][23:0]             dac_out_l,
  output logic [2:0][23:0]             dac_out_r,
  output logic [2:0][7:0]              dac_volume_applied,
  output logic [2:0]                   dac_per_channel_deemphasis_on,
  output logic [2:0]                   dac_low_power,
  output logic                         dac_filter_init,
  // ADC sample path and control
  input  wire logic                    adc_sample_stb,
  input  wire logic [23:0]             adc_in_l,
  input  wire logic [23:0]             adc_in_r,
  output logic                         adc_out_stb,
  output logic [23:0]                  adc_out_l,
  output logic [23:0]                  adc_out_r,
  output logic                         adc_low_power,
  output logic                         adc_filter_init
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sclk_sync_reg;
  logic [1:0] sdat_sync_reg;
  logic [1:0] slat_sync_reg;
  logic [1:0] mpin_sync_reg;
  logic       sclk_prev_reg;
  logic       slat_prev_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      {sclk_sync_reg, sdat_sync_reg, slat_sync_reg, mpin_sync_reg, sclk_prev_reg, slat_prev_reg} <= 10'h0;
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], ser_clk};
      sdat_sync_reg <= {sdat_sync_reg[0], ser_data};
      slat_sync_reg <= {slat_sync_reg[0], ser_latch};
      mpin_sync_reg <= {mpin_sync_reg[0], mute_pin_in};
      sclk_prev_reg <= sclk_sync_reg[1];
      slat_prev_reg <= slat_sync_reg[1];
    end
  end

  // ---------------------------------------------------------------
  // Serial shift register
  // ---------------------------------------------------------------
  logic [15:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic        sclk_rise;
  logic        latch_rise;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [8:0]  wr_data;

  assign sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign latch_rise = slat_sync_reg[1] & ~slat_prev_reg;
  assign wr_en      = latch_rise && (bit_cnt_reg >= 5'(CTRL_WORD_BITS));
  assign wr_addr    = shift_reg[15:9];
  assign wr_data    = shift_reg[8:0];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      {shift_reg, bit_cnt_reg} <= 21'h0;
    else if (latch_rise)
      bit_cnt_reg <= 5'h00;
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[14:0], sdat_sync_reg[1]};
      if (bit_cnt_reg < 5'(CTRL_WORD_BITS))
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [8:0] mute_per_channel_deemphasis_pd_reg;
  logic [8:0] output_phase_reg;
  logic [8:0] flag_mute_ctrl_reg;
  logic [8:0] conv_disable_reg;
  logic [8:0] adc_input_mute_reg;

  // Power-down leaves these untouched [R11]
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mute_per_channel_deemphasis_pd_reg <= RST_MUTE_PER_CHANNEL_DEEMPHASIS_PD;
      output_phase_reg   <= RST_OUTPUT_PHASE;
      flag_mute_ctrl_reg <= RST_FLAG_MUTE_CTRL;
      conv_disable_reg   <= RST_CONV_DISABLE;
      adc_input_mute_reg <= RST_ADC_INPUT_MUTE;
    end
    else if (wr_en)
    begin
      unique case (wr_addr)
        ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD: mute_per_channel_deemphasis_pd_reg <= wr_data;
        ADDR_OUTPUT_PHASE:   output_phase_reg   <= wr_data;
        ADDR_FLAG_MUTE_CTRL: flag_mute_ctrl_reg <= wr_data;
        ADDR_CONV_DISABLE:   conv_disable_reg   <= wr_data;
        ADDR_ADC_INPUT_MUTE: adc_input_mute_reg <= wr_data;
        default:             ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  logic       dac_global_powerdown;
  logic [3:0] channel_routing_select;
  logic [2:0] phase_invert;
  logic       volume_zero_cross_disable;
  logic [1:0] zero_flag_select;
  logic [2:0] per_channel_soft_mute;
  logic       global_soft_mute;
  logic [2:0] per_channel_deemphasis;
  logic       global_deemphasis;
  logic       adc_disable;
  logic [2:0] dac_channel_disable;
  logic       mute_pin_decode_disable;
  logic [2:0] soft_mute_req;

  assign dac_global_powerdown      = mute_per_channel_deemphasis_pd_reg[DAC_GLOBAL_PD_BIT];
  assign channel_routing_select    = mute_per_channel_deemphasis_pd_reg[ROUTING_LSB +: 4];
  assign global_soft_mute          = mute_per_channel_deemphasis_pd_reg[GLOBAL_SOFT_MUTE_BIT];
  assign global_deemphasis         = mute_per_channel_deemphasis_pd_reg[GLOBAL_DEEMPHASIS_BIT];
  assign phase_invert              = output_phase_reg[PHASE_LSB +: 3];
  assign volume_zero_cross_disable = flag_mute_ctrl_reg[ZERO_CROSS_DISABLE_BIT];
  assign zero_flag_select          = flag_mute_ctrl_reg[FLAG_SELECT_LSB +: 2];
  assign per_channel_soft_mute     = flag_mute_ctrl_reg[SOFT_MUTE_LSB +: 3];
  assign per_channel_deemphasis    = flag_mute_ctrl_reg[DEEMPHASIS_LSB +: 3];
  assign adc_disable               = conv_disable_reg[ADC_DISABLE_BIT];
  assign dac_channel_disable       = conv_disable_reg[DAC_DISABLE_LSB +: 3];
  assign mute_pin_decode_disable   = adc_input_mute_reg[MUTE_PIN_DECODE_DIS_BIT];

  // Soft mute sources combined per channel
  assign soft_mute_req = per_channel_soft_mute                                   // [R5]
                       | {3{global_soft_mute}}                                   // [R6]
                       | {3{mute_pin_decode_disable & mpin_sync_reg[1]}};        // [R15]

  // ---------------------------------------------------------------
  // Sample helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] route_pick(input logic [1:0] sel,
                                             input logic [23:0] l,
                                             input logic [23:0] r);
    logic [24:0] sum;
    sum = {l[23], l} + {r[23], r};
    unique case (sel)
      2'h0: route_pick = 24'h000000;
      2'h1: route_pick = l;
      2'h2: route_pick = r;
      2'h3: route_pick = sum[24:1];
    endcase
  endfunction

  function automatic logic [23:0] neg_sat(input logic [23:0] x);
    neg_sat = (x == 24'h800000) ? 24'h7fffff : 24'(-x);
  endfunction

  function automatic logic [23:0] scale(input logic [23:0] x,
                                        input logic [8:0] g);
    logic signed [33:0] p;
    p = $signed(x) * $signed({1'b0, g});
    scale = p[31:8];
  endfunction

  // ---------------------------------------------------------------
  // DAC channels
  // ---------------------------------------------------------------
  logic [2:0] chan_zero;
  logic [2:0] pd_gate;

  assign pd_gate = dac_channel_disable | {3{dac_global_powerdown}};               // [R11] [R14]
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_chan
      logic [8:0]  gain_reg;
      logic [10:0] zrun_reg;
      logic        sign_prev_reg;
      logic [23:0] src_l;
      logic [23:0] src_r;
      logic [23:0] ph_l;
      logic [23:0] ph_r;
      logic        crossing;

      // Abrupt mute on routing zero, no ramp [R7]
      assign src_l    = route_pick(channel_routing_select[1:0], dac_in_l[ch], dac_in_r[ch]);
      assign src_r    = route_pick(channel_routing_select[3:2], dac_in_l[ch], dac_in_r[ch]);
      assign ph_l     = phase_invert[ch] ? neg_sat(src_l) : src_l;                 // [R1]
      assign ph_r     = phase_invert[ch] ? neg_sat(src_r) : src_r;                 // [R1]
      assign crossing = (dac_in_l[ch] == 24'h000000) || (dac_in_l[ch][23] != sign_prev_reg);

      // Soft mute gain ramp, one step per sample
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          gain_reg <= GAIN_FULL;
        else if (pd_gate[ch])
          gain_reg <= GAIN_FULL;                                                   // [R11]
        else if (dac_sample_stb && soft_mute_req[ch] && gain_reg != 9'h000)
          gain_reg <= gain_reg - GAIN_STEP;                                        // [R16]
        else if (dac_sample_stb && !soft_mute_req[ch] && gain_reg != GAIN_FULL)
          gain_reg <= gain_reg + GAIN_STEP;                                        // [R16]
      end

      // Zero run counter and sign history
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          {zrun_reg, sign_prev_reg} <= 12'h0;
        else if (dac_global_powerdown)
          {zrun_reg, sign_prev_reg} <= 12'h0;                                      // [R11]
        else if (dac_sample_stb)
        begin
          sign_prev_reg <= dac_in_l[ch][23];
          if (dac_in_l[ch] != 24'h000000 || dac_in_r[ch] != 24'h000000)
            zrun_reg <= 11'h000;
          else if (zrun_reg != ZERO_RUN)
            zrun_reg <= zrun_reg + 11'h001;                                        // [R3]
        end
      end

      assign chan_zero[ch] = (zrun_reg == ZERO_RUN);                               // [R3]
      // Volume applied on a zero crossing
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          dac_volume_applied[ch] <= 8'hff;
        else if (dac_sample_stb && (volume_zero_cross_disable || crossing))
          dac_volume_applied[ch] <= dac_volume_target[ch];                         // [R2]
      end

      // Output samples
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          {dac_out_l[ch], dac_out_r[ch]} <= 48'h0;
        else if (pd_gate[ch])
          {dac_out_l[ch], dac_out_r[ch]} <= 48'h0;                                 // [R7] [R11]
        else if (dac_sample_stb)
          {dac_out_l[ch], dac_out_r[ch]} <= {scale(ph_l, gain_reg), scale(ph_r, gain_reg)};  // [R5] [R6]
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // DAC strobe, filter init and zero flag pin
  // ---------------------------------------------------------------
  logic pd_prev_reg;
  logic flag_sel;

  always_comb
  begin
    unique case (zero_flag_select)
      FLAG_ALL: flag_sel = &chan_zero;                                             // [R4]
      2'h1:     flag_sel = chan_zero[0];                                           // [R4]
      2'h2:     flag_sel = chan_zero[1];                                           // [R4]
      2'h3:     flag_sel = chan_zero[2];                                           // [R4]
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {pd_prev_reg, dac_filter_init, dac_out_stb, zero_flag_pin} <= 4'h0;
      {zero_flag_pin_oe_n, dac_per_channel_deemphasis_on, dac_low_power}        <= 7'h00;
    end
    else
    begin
      pd_prev_reg        <= dac_global_powerdown;
      dac_filter_init    <= pd_prev_reg & ~dac_global_powerdown;                   // [R12]
      dac_out_stb        <= dac_sample_stb & ~dac_global_powerdown;
      zero_flag_pin      <= flag_sel;                                              // [R3]
      zero_flag_pin_oe_n <= mute_pin_decode_disable;                               // [R15]
      dac_per_channel_deemphasis_on      <= per_channel_deemphasis | {3{global_deemphasis}};       // [R9] [R10]
      dac_low_power      <= pd_gate;                                               // [R11] [R14]
    end
  end

  // ---------------------------------------------------------------
  // ADC mute and disable
  // ---------------------------------------------------------------
  logic adc_dis_prev_reg;
  logic adc_mute_l;
  logic adc_mute_r;

  assign adc_mute_r = adc_input_mute_reg[ADC_RIGHT_SILENCE_BIT] | adc_input_mute_reg[ADC_BOTH_SILENCE_BIT];
  assign adc_mute_l = adc_input_mute_reg[ADC_LEFT_SILENCE_BIT] | adc_input_mute_reg[ADC_BOTH_SILENCE_BIT];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      {adc_out_l, adc_out_r, adc_out_stb} <= 49'h0;
    else
    begin
      adc_out_stb <= adc_sample_stb & ~adc_disable;                               // [R13]
      if (adc_disable)
        {adc_out_l, adc_out_r} <= 48'h0;
      else if (adc_sample_stb)
      begin
        adc_out_l <= adc_mute_l ? 24'h000000 : adc_in_l;                           // [R8]
        adc_out_r <= adc_mute_r ? 24'h000000 : adc_in_r;                           // [R8]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      {adc_dis_prev_reg, adc_low_power, adc_filter_init} <= 3'h0;
    else
    begin
      adc_dis_prev_reg <= adc_disable;
      adc_low_power    <= adc_disable;                                             // [R13]
      adc_filter_init  <= adc_dis_prev_reg & ~adc_disable;                         // [R13]
    end
  end

endmodule

/* design/cmc_pkg.sv */
/*
  Constants for the codec mute, phase, de-emphasis and power control block:
  register addresses, field positions, reset values and datapath figures.
  Assumes a 16-bit serial control word of a 7-bit address and 9-bit data.
*/
package cmc_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD  = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT_PHASE    = 7'h03;
  localparam logic [6:0] ADDR_FLAG_MUTE_CTRL  = 7'h09;
  localparam logic [6:0] ADDR_CONV_DISABLE    = 7'h0a;
  localparam logic [6:0] ADDR_ADC_INPUT_MUTE  = 7'h0c;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [8:0] RST_MUTE_PER_CHANNEL_DEEMPHASIS_PD   = 9'h120;
  localparam logic [8:0] RST_OUTPUT_PHASE     = 9'h000;
  localparam logic [8:0] RST_FLAG_MUTE_CTRL   = 9'h000;
  localparam logic [8:0] RST_CONV_DISABLE     = 9'h000;
  localparam logic [8:0] RST_ADC_INPUT_MUTE   = 9'h000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GLOBAL_SOFT_MUTE_BIT     = 0;
  localparam int GLOBAL_DEEMPHASIS_BIT    = 1;
  localparam int DAC_GLOBAL_PD_BIT        = 2;
  localparam int ROUTING_LSB              = 5;
  localparam int PHASE_LSB                = 6;
  localparam int ZERO_CROSS_DISABLE_BIT   = 0;
  localparam int FLAG_SELECT_LSB          = 1;
  localparam int SOFT_MUTE_LSB            = 3;
  localparam int DEEMPHASIS_LSB           = 6;
  localparam int ADC_DISABLE_BIT          = 0;
  localparam int DAC_DISABLE_LSB          = 1;
  localparam int ADC_RIGHT_SILENCE_BIT    = 0;
  localparam int ADC_LEFT_SILENCE_BIT     = 1;
  localparam int ADC_BOTH_SILENCE_BIT     = 2;
  localparam int MUTE_PIN_DECODE_DIS_BIT  = 6;

  // ---------------------------------------------------------------
  // Datapath figures
  // ---------------------------------------------------------------
  localparam int         CTRL_WORD_BITS = 16;
  localparam logic [10:0] ZERO_RUN      = 11'h400;
  localparam logic [8:0]  GAIN_FULL     = 9'h100;
  localparam logic [8:0]  GAIN_STEP     = 9'h001;
  localparam logic [1:0]  FLAG_ALL      = 2'h0;

endpackage

/* verif/cmc_core_checker.sv */
/*
  Port checker for cmc_core: strobe, volume, zero flag and power timing.
  Assumes it is bound to cmc_core by the statement at the foot.
*/
`timescale 1ns/1ps
module cmc_core_checker
  import cmc_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rstn,
  // DAC side
  input wire logic             dac_sample_stb,
  input wire logic [2:0][23:0] dac_in_l,
  input wire logic [2:0][23:0] dac_in_r,
  input wire logic [2:0][7:0]  dac_volume_target,
  input wire logic             dac_out_stb,
  input wire logic [2:0][23:0] dac_out_l,
  input wire logic [2:0][23:0] dac_out_r,
  input wire logic [2:0][7:0]  dac_volume_applied,
  input wire logic [2:0]       dac_low_power,
  input wire logic             dac_filter_init,
  input wire logic             zero_flag_pin,
  // ADC side
  input wire logic             adc_sample_stb,
  input wire logic             adc_out_stb,
  input wire logic             adc_low_power,
  input wire logic             adc_filter_init
);
  // ---------------
  // Zero run count
  // ---------------
  logic [10:0] run_reg [3];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      run_reg <= '{default: 11'h000};
    else if (dac_sample_stb)
      for (int i = 0; i < 3; i++)
        run_reg[i] <= (dac_in_l[i] != 24'h0 || dac_in_r[i] != 24'h0) ? 11'h000 :
                      (run_reg[i] == ZERO_RUN) ? ZERO_RUN : run_reg[i] + 11'h001;
  stb_follow_a: assert property (dac_out_stb |-> $past(dac_sample_stb))
    else $error("dac strobe without input strobe");
  adc_stb_a: assert property (adc_out_stb |-> $past(adc_sample_stb))
    else $error("adc strobe without input strobe");
  vol_apply_a: assert property ($changed(dac_volume_applied[0]) |->
    $past(dac_sample_stb) && dac_volume_applied[0] == $past(dac_volume_target[0]))
    else $error("volume applied off a strobe");
  flag_run_a: assert property ($rose(zero_flag_pin) |->
    run_reg[0] == ZERO_RUN || run_reg[1] == ZERO_RUN || run_reg[2] == ZERO_RUN)
    else $error("zero flag before full zero run");
  chan_off_a: assert property ($past(dac_low_power[1]) && dac_low_power[1] && dac_out_stb |->
    dac_out_l[1] == 24'h0 && dac_out_r[1] == 24'h0)
    else $error("disabled channel gives output");
  dac_init_a: assert property (dac_filter_init |-> $past(dac_low_power) == 3'h7)
    else $error("dac filter init without power down");
  init_pulse_a: assert property (dac_filter_init |=> !dac_filter_init)
    else $error("dac filter init too long");
  adc_init_a: assert property (adc_filter_init |-> $past(adc_low_power) && !adc_low_power)
    else $error("adc filter init off release");
  adc_off_a: assert property (adc_low_power && $past(adc_low_power) |-> !adc_out_stb)
    else $error("adc strobe while disabled");
endmodule
bind cmc_core cmc_core_checker u_chk (.*);

/* verif/cmc_core_tb_top.sv */
/*
  Testbench for cmc_core: scenario tasks drive samples and host writes.
  Assumes cmc_host_model and the bound checker.
*/
`timescale 1ns/1ps
module cmc_core_tb_top;
  import cmc_pkg::*;
  // --------
  // Signals
  // --------
  logic             sys_clk = 1'b0;
  logic             rstn = 1'b0;
  logic             mute_pin_in = 1'b0;
  logic             dac_sample_stb = 1'b0;
  logic             adc_sample_stb = 1'b0;
  logic [2:0][23:0] dac_in_l = '0;
  logic [2:0][23:0] dac_in_r = '0;
  logic [2:0][7:0]  dac_volume_target = '1;
  logic [23:0]      adc_in_l = '0;
  logic [23:0]      adc_in_r = '0;
  logic [2:0][23:0] dac_out_l, dac_out_r;
  logic [2:0][7:0]  dac_volume_applied;
  logic [2:0]       dac_per_channel_deemphasis_on, dac_low_power;
  logic [23:0]      adc_out_l, adc_out_r;
  logic             ser_clk, ser_data, ser_latch, zero_flag_pin, zero_flag_pin_oe_n;
  logic             dac_out_stb, dac_filter_init, adc_out_stb, adc_low_power, adc_filter_init;
  int               failures = 0;
  int               n_tests = 0;
  int               n_dinit = 0;
  int               n_ainit = 0;
  int               n_dstb = 0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    n_dinit += int'(dac_filter_init === 1'b1);
    n_ainit += int'(adc_filter_init === 1'b1);
    n_dstb += int'(dac_out_stb === 1'b1);
  end
  cmc_core u_dut (.*);
  cmc_host_model u_host (.*);
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    u_host.send({a, d});
  endtask
  task automatic smp(input logic [23:0] l, input logic [23:0] r, input logic [2:0] zm);
    for (int i = 0; i < 3; i++)
    begin
      dac_in_l[i] = zm[i] ? 24'h0 : l;
      dac_in_r[i] = zm[i] ? 24'h0 : r;
    end
    adc_in_l = l;
    adc_in_r = r;
    dac_sample_stb = 1'b1;
    adc_sample_stb = 1'b1;
    tick(1);
    dac_sample_stb = 1'b0;
    adc_sample_stb = 1'b0;
    tick(1);
  endtask
  task automatic ramp(input int ch, input logic [23:0] d, input logic [23:0] p);
    repeat (5)
    begin
      smp(24'h100, 24'h100, 3'h0);
      chk(72'(dac_out_l[ch]), 72'(p));
      p += d;
    end
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    chk(72'(dac_volume_applied), 72'hffffff);
    chk(72'({zero_flag_pin, zero_flag_pin_oe_n, dac_low_power, dac_per_channel_deemphasis_on, adc_low_power}), 72'h0);
    smp(24'h64, 24'hffffce, 3'h0);
    chk(72'(dac_out_l), {3{24'h64}});
  endtask
  task automatic t_phase;
    wr(ADDR_OUTPUT_PHASE, 9'h040);
    smp(24'h64, 24'hffffce, 3'h0);
    chk(72'(dac_out_l), {24'h64, 24'h64, 24'hffff9c});
    chk(72'(dac_out_r), {24'hffffce, 24'hffffce, 24'h32});
    wr(ADDR_OUTPUT_PHASE, 9'h180);
    smp(24'h64, 24'hffffce, 3'h0);
    chk(72'(dac_out_l), {24'hffff9c, 24'hffff9c, 24'h64});
    wr(ADDR_OUTPUT_PHASE, 9'h000);
  endtask
  task automatic t_soft;
    wr(ADDR_FLAG_MUTE_CTRL, 9'h008);
    ramp(0, 24'hffffff, 24'h100);
    chk(72'(dac_out_l[1]), 72'h100);
    wr(ADDR_FLAG_MUTE_CTRL, 9'h000);
    ramp(0, 24'h000001, 24'h0fb);
    repeat (300) smp(24'h100, 24'h100, 3'h0);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h121);
    ramp(2, 24'hffffff, 24'h100);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h120);
    repeat (300) smp(24'h100, 24'h100, 3'h0);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h000);
    smp(24'h100, 24'h100, 3'h0);
    chk(72'(dac_out_l), 72'h0);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h120);
  endtask
  task automatic t_vol;
    dac_volume_target = {3{8'h80}};
    smp(24'h64, 24'h64, 3'h0);
    chk(72'(dac_volume_applied), 72'hffffff);
    smp(24'hffff9c, 24'h64, 3'h0);
    chk(72'(dac_volume_applied), 72'h808080);
    wr(ADDR_FLAG_MUTE_CTRL, 9'h001);
    dac_volume_target = {3{8'h40}};
    smp(24'hffff9c, 24'h64, 3'h0);
    chk(72'(dac_volume_applied), 72'h404040);
    wr(ADDR_FLAG_MUTE_CTRL, 9'h000);
  endtask
  task automatic t_flag;
    logic [2:0] z;
    logic [2:0] zx;
    for (int s = 0; s < 4; s++)
    begin
      z = (s == 0) ? 3'h7 : 3'(1 << (s - 1));
      zx = (s == 0) ? 3'h3 : ~z;
      wr(ADDR_FLAG_MUTE_CTRL, 9'(s << 1));
      repeat (1024) smp(24'h5, 24'h5, zx);
      chk(72'(zero_flag_pin), 72'h0);
      smp(24'h5, 24'h5, 3'h0);
      repeat (1023) smp(24'h5, 24'h5, z);
      chk(72'(zero_flag_pin), 72'h0);
      smp(24'h5, 24'h5, z);
      chk(72'(zero_flag_pin), 72'h1);
      smp(24'h5, 24'h5, 3'h0);
      chk(72'(zero_flag_pin), 72'h0);
    end
    wr(ADDR_FLAG_MUTE_CTRL, 9'h000);
  endtask
  task automatic t_per_channel_deemphasis;
    wr(ADDR_FLAG_MUTE_CTRL, 9'h140);
    chk(72'(dac_per_channel_deemphasis_on), 72'h5);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h122);
    chk(72'(dac_per_channel_deemphasis_on), 72'h7);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h120);
    wr(ADDR_FLAG_MUTE_CTRL, 9'h000);
    chk(72'(dac_per_channel_deemphasis_on), 72'h0);
  endtask
  task automatic t_adc;
    for (int m = 0; m < 8; m++)
    begin
      wr(ADDR_ADC_INPUT_MUTE, 9'(m));
      smp(24'h5, 24'h7, 3'h0);
      chk(72'(adc_out_r), (m[0] | m[2]) ? 72'h0 : 72'h7);
      chk(72'(adc_out_l), (m[1] | m[2]) ? 72'h0 : 72'h5);
    end
    wr(ADDR_ADC_INPUT_MUTE, 9'h000);
    wr(ADDR_CONV_DISABLE, 9'h001);
    smp(24'h5, 24'h7, 3'h0);
    chk(72'({adc_low_power, adc_out_l}), 72'h1000000);
    wr(ADDR_CONV_DISABLE, 9'h000);
    chk(72'(n_ainit), 72'h1);
  endtask
  task automatic t_pd;
    int s;
    wr(ADDR_CONV_DISABLE, 9'h004);
    smp(24'h64, 24'h64, 3'h0);
    chk(72'(dac_low_power), 72'h2);
    chk(72'(dac_out_l), {24'h64, 24'h0, 24'h64});
    wr(ADDR_CONV_DISABLE, 9'h00e);
    chk(72'(dac_low_power), 72'h7);
    wr(ADDR_CONV_DISABLE, 9'h000);
    wr(ADDR_OUTPUT_PHASE, 9'h040);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h124);
    chk(72'(dac_low_power), 72'h7);
    s = n_dstb;
    smp(24'h64, 24'h64, 3'h0);
    chk(72'(n_dstb - s), 72'h0);
    wr(ADDR_MUTE_PER_CHANNEL_DEEMPHASIS_PD, 9'h120);
    chk(72'(n_dinit), 72'h1);
    smp(24'h64, 24'h64, 3'h0);
    chk(72'(dac_out_l[0]), 72'hffff9c);
    wr(ADDR_OUTPUT_PHASE, 9'h000);
  endtask
  task automatic t_pin;
    wr(ADDR_ADC_INPUT_MUTE, 9'h040);
    chk(72'(zero_flag_pin_oe_n), 72'h1);
    mute_pin_in = 1'b1;
    tick(4);
    ramp(2, 24'hffffff, 24'h100);
    mute_pin_in = 1'b0;
  endtask
  initial
  begin
    tick(12);
    rstn = 1'b1;
    tick(1);
    t_reset();
    t_phase();
    t_soft();
    t_vol();
    t_flag();
    t_per_channel_deemphasis();
    t_adc();
    t_pd();
    t_pin();
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end
endmodule

/* verif/cmc_host_model.sv */
/*
  Host model: writes 16-bit control words on the 3-wire serial pins.
  Assumes a 50 MHz sys_clk; every pin level stands at least 3 cycles.
*/
`timescale 1ns/1ps
module cmc_host_model
(
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_latch
);
  // -----------
  // Word write
  // -----------
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  task automatic hold;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      ser_data = w[i];
      hold();
      ser_clk = 1'b1;
      hold();
      ser_clk = 1'b0;
      hold();
    end
    ser_data = ~w[0];
    ser_latch = 1'b1;
    hold();
    ser_latch = 1'b0;
    hold();
  endtask
endmodule
